/* File: design/wdt_pkg.sv */
/*
 * Constants for the windowed watchdog timer: register offsets, field
 * positions, reset values, service codes and timing counts.
 * Assumes a 100 MHz APB clock with 32-bit data and word-aligned registers.
 */
package wdt_pkg;

    // Register byte offsets.
    localparam logic [7:0] WDT_OFS_RESET_STATUS = 8'h00;
    localparam logic [7:0] WDT_OFS_OPTIONS_ONE = 8'h04;
    localparam logic [7:0] WDT_OFS_OPTIONS_TWO = 8'h08;
    localparam logic [7:0] WDT_OFS_COUNT = 8'h0c;
    localparam logic [7:0] WDT_OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] WDT_OFS_IRQ_MASK = 8'h14;

    // Field positions.
    localparam int WDT_TSEL_LSB = 0;
    localparam int WDT_CLKSEL_BIT = 7;
    localparam int WDT_WINEN_BIT = 6;
    localparam int WDT_RS_ENABLED_BIT = 0;
    localparam int WDT_RS_ARMED_BIT = 1;
    localparam int WDT_RS_WINOPEN_BIT = 2;
    localparam int WDT_RS_LOCKED_BIT = 3;
    localparam int WDT_EV_TIMEOUT = 0;
    localparam int WDT_EV_BADCODE = 1;
    localparam int WDT_EV_EARLY = 2;
    localparam int WDT_EV_SERVICED = 3;
    localparam int WDT_EV_W = 4;

    // Reset values.
    localparam logic [1:0] WDT_TSEL_RESET = 2'h3;
    localparam logic WDT_CLKSEL_RESET = 1'b0;
    localparam logic WDT_WINEN_RESET = 1'b0;
    localparam logic [WDT_EV_W-1:0] WDT_MASK_RESET = 4'h0;

    // Service codes written to the reset status address.
    localparam logic [31:0] WDT_CODE_FIRST = 32'h0000_0055;
    localparam logic [31:0] WDT_CODE_SECOND = 32'h0000_00aa;

    // Counter width covers the longest overflow count.
    localparam int WDT_CNT_W = 18;

    // Overflow counts as powers of two, for codes 01, 10 and 11.
    localparam int WDT_LPO_EXP1 = 5;
    localparam int WDT_LPO_EXP2 = 8;
    localparam int WDT_LPO_EXP3 = 10;
    localparam int WDT_BUS_EXP1 = 13;
    localparam int WDT_BUS_EXP2 = 16;
    localparam int WDT_BUS_EXP3 = 18;

    // The window opens once three quarters of the period have passed.
    localparam int WDT_WIN_NUM = 3;
    localparam int WDT_WIN_DEN = 4;

    // Low-power clock period and the bus clock period, in nanoseconds.
    localparam int WDT_LPO_PERIOD_NS = 1000000;
    localparam int WDT_PCLK_PERIOD_NS = 10;
    localparam int WDT_LPO_DIV = WDT_LPO_PERIOD_NS / WDT_PCLK_PERIOD_NS;

    typedef enum logic [1:0] {
        WDT_APB_IDLE,
        WDT_APB_WAIT,
        WDT_APB_DONE
    } wdt_apb_type;

endpackage : wdt_pkg

/* File: design/wdt_top.sv */
/*
 * Windowed watchdog timer with an APB register slave and a level interrupt.
 * Assumes one 100 MHz clock, an asynchronous active-low reset that the system
 * reset logic asserts after a reset request, and an APB master on pclk.
 */
// What this block does
// R01: After any reset, watchdog runs without software.
// R02: Timeout code zero disables counting, timeout and early resets.
// R03: Software writes 0x0055 then 0x00AA to service.
// R04: Service writes leave reset status contents unchanged except the window-open bit.
// R05: Completed sequence clears counter, restarts period.
// R06: Counter overflow issues a system reset request.
// R07: Any other written value requests reset at once.
// R08: Clock select: 0 low-power clock, 1 bus.
// R09: Three nonzero timeout codes pick three counts.
// R10: Counts 2^5/2^8/2^10 and 2^13/2^16/2^18.
// R11: Reset default: low-power clock, longest timeout.
// R12: Window opens in the final quarter of period.
// R13: Window needs window enable and bus clock.
// R14: Service before window opens requests reset.
// R15: Low-power clock ignores window enable bit.
// R16: Clock and window bits accept first write only.
// R17: Reset request is one registered pulse.
`timescale 1ns/1ns
module wdt_top
    import wdt_pkg::*;
#(
    parameter int LPO_DIV = WDT_LPO_DIV
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wdt_reset_req,
    output logic wdt_irq
);

    // Overflow count for a clock source and timeout code.
    // Code zero gives zero; the enable term keeps that from acting except on the window-open status bit.
    function automatic logic [WDT_CNT_W:0] wdt_limit(input logic bus_src, input logic [1:0] tsel);
        logic [WDT_CNT_W:0] lim;
        lim = '0;
        unique case (tsel)
            2'h1: lim[bus_src ? WDT_BUS_EXP1 : WDT_LPO_EXP1] = 1'b1;
            2'h2: lim[bus_src ? WDT_BUS_EXP2 : WDT_LPO_EXP2] = 1'b1;
            2'h3: lim[bus_src ? WDT_BUS_EXP3 : WDT_LPO_EXP3] = 1'b1;
            2'h0: lim = '0;
        endcase
        return lim;
    endfunction : wdt_limit

    // Decode of a mapped register offset, used only for the slave error path.
    function automatic logic wdt_mapped(input logic [7:0] addr);
        return addr == WDT_OFS_RESET_STATUS || addr == WDT_OFS_OPTIONS_ONE ||
            addr == WDT_OFS_OPTIONS_TWO || addr == WDT_OFS_COUNT ||
            addr == WDT_OFS_IRQ_STATUS || addr == WDT_OFS_IRQ_MASK;
    endfunction : wdt_mapped

    wdt_apb_type apb_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [1:0] timeout_select_q;
    logic watchdog_clock_select_q;
    logic window_enable_q;
    logic options_two_locked_q;
    logic [31:0] lpo_div_q;
    logic lpo_tick_q;
    logic [WDT_CNT_W-1:0] count_q;
    logic armed_q;
    logic reset_req_q;
    logic [WDT_EV_W-1:0] ev_status_q;
    logic [WDT_EV_W-1:0] ev_mask_q;
    logic irq_q;

    logic done;
    logic wr_done;
    logic rd_done;
    logic enabled;
    logic window_mode;
    logic tick;
    logic [WDT_CNT_W:0] limit;
    logic [WDT_CNT_W:0] win_open;
    logic win_is_open;
    logic overflow;
    logic srs_write;
    logic code_first;
    logic code_second;
    logic bad_code;
    logic early;
    logic serviced;
    logic [WDT_EV_W-1:0] ev_set;
    logic [31:0] rd_value;

    // The transfer completes at the edge where the master sees pready high.
    assign done = psel && penable && pready_q;
    assign wr_done = done && pwrite && !pslverr_q;
    assign rd_done = done && !pwrite && !pslverr_q;

    // Window mode needs the bus clock; on the slow clock the enable bit is kept but ignored.
    assign enabled = timeout_select_q != 2'h0; // R02
    assign window_mode = window_enable_q && watchdog_clock_select_q; // R13 R15
    assign tick = watchdog_clock_select_q ? 1'b1 : lpo_tick_q; // R08
    assign limit = wdt_limit(watchdog_clock_select_q, timeout_select_q); // R09 R10
    assign win_open = (WDT_CNT_W + 1)'((limit / WDT_WIN_DEN) * WDT_WIN_NUM); // R12
    assign win_is_open = {1'b0, count_q} >= win_open;
    // Greater-or-equal rather than equal: shortening the timeout below the
    // present count must still end the period instead of waiting for a wrap.
    assign overflow = enabled && tick && ({1'b0, count_q} >= limit - 1'b1); // R06

    // Only completed transfers without a slave error act on the service address.
    assign srs_write = wr_done && paddr == WDT_OFS_RESET_STATUS;
    assign code_first = srs_write && pwdata == WDT_CODE_FIRST;
    assign code_second = srs_write && pwdata == WDT_CODE_SECOND;
    assign bad_code = srs_write && !code_first && !code_second; // R07
    // In window mode every service code before the window opens is early,
    // a lone second code included, and requests a reset at once.
    assign early = srs_write && !bad_code && enabled && window_mode && !win_is_open; // R14
    assign serviced = code_second && armed_q && !early; // R03 R05

    assign ev_set = {serviced, early, bad_code, overflow};

    always_comb
    begin
        rd_value = 32'h0000_0000;
        unique case (paddr)
            WDT_OFS_RESET_STATUS:
            begin
                rd_value[WDT_RS_ENABLED_BIT] = enabled;
                // The arm state is not shown, so that a service write never
                // changes what this read-only register returns except in the window-open bit.
                rd_value[WDT_RS_WINOPEN_BIT] = window_mode && win_is_open;
                rd_value[WDT_RS_LOCKED_BIT] = options_two_locked_q;
            end
            WDT_OFS_OPTIONS_ONE: rd_value[WDT_TSEL_LSB +: 2] = timeout_select_q;
            WDT_OFS_OPTIONS_TWO:
            begin
                rd_value[WDT_CLKSEL_BIT] = watchdog_clock_select_q;
                rd_value[WDT_WINEN_BIT] = window_enable_q;
            end
            WDT_OFS_COUNT: rd_value[WDT_CNT_W-1:0] = count_q;
            WDT_OFS_IRQ_STATUS: rd_value[WDT_EV_W-1:0] = ev_status_q;
            WDT_OFS_IRQ_MASK: rd_value[WDT_EV_W-1:0] = ev_mask_q;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // One wait state lets pready and prdata come straight from flip-flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apb_q <= WDT_APB_IDLE;
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            unique case (apb_q)
                WDT_APB_IDLE:
                begin
                    if (psel && !penable)
                    begin
                        apb_q <= WDT_APB_WAIT;
                    end
                end
                WDT_APB_WAIT:
                begin
                    apb_q <= WDT_APB_DONE;
                    pready_q <= 1'b1;
                    // A write carries no read data, so prdata stays zero for it.
                    prdata_q <= pwrite ? 32'h0000_0000 : rd_value;
                    pslverr_q <= !wdt_mapped(paddr);
                end
                WDT_APB_DONE:
                begin
                    apb_q <= WDT_APB_IDLE;
                    pready_q <= 1'b0;
                    prdata_q <= 32'h0000_0000;
                    pslverr_q <= 1'b0;
                end
            endcase
        end
    end

    // Timeout select stays writable; reset puts it on the longest period.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timeout_select_q <= WDT_TSEL_RESET; // R01 R11
        end
        else if (wr_done && paddr == WDT_OFS_OPTIONS_ONE)
        begin
            timeout_select_q <= pwdata[WDT_TSEL_LSB +: 2];
        end
    end

    // Clock source and window mode lock after the first write so that a
    // runaway program cannot weaken the watchdog.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watchdog_clock_select_q <= WDT_CLKSEL_RESET; // R11
            window_enable_q <= WDT_WINEN_RESET;
            options_two_locked_q <= 1'b0;
        end
        else if (wr_done && paddr == WDT_OFS_OPTIONS_TWO && !options_two_locked_q)
        begin
            watchdog_clock_select_q <= pwdata[WDT_CLKSEL_BIT]; // R16
            window_enable_q <= pwdata[WDT_WINEN_BIT];
            options_two_locked_q <= 1'b1;
        end
    end

    // The 1 kHz low-power clock is an enable pulse from a divider.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lpo_div_q <= 32'h0000_0000;
            lpo_tick_q <= 1'b0;
        end
        else if (lpo_div_q == 32'(LPO_DIV - 1))
        begin
            lpo_div_q <= 32'h0000_0000;
            lpo_tick_q <= 1'b1;
        end
        else
        begin
            lpo_div_q <= lpo_div_q + 32'h0000_0001;
            lpo_tick_q <= 1'b0;
        end
    end

    // Any reset request restarts the count, whichever event raised it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= '0; // R17
        end
        else if (!enabled || serviced || overflow || reset_req_q)
        begin
            count_q <= '0; // R02 R05
        end
        else if (tick)
        begin
            count_q <= count_q + 1'b1;
        end
    end

    // The first code arms the sequence; anything else written disarms it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_q <= 1'b0; // R17
        end
        else if (srs_write)
        begin
            armed_q <= code_first && !early; // R03
        end
        else if (reset_req_q)
        begin
            armed_q <= 1'b0;
        end
    end

    // The request is a one-cycle pulse; the system reset logic stretches it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reset_req_q <= 1'b0;
        end
        else
        begin
            reset_req_q <= overflow || bad_code || early; // R06 R07 R14 R17
        end
    end

    // Sticky events; a read of the status register clears them, but an
    // event in the same cycle as the read is kept.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_status_q <= '0;
        end
        else if (rd_done && paddr == WDT_OFS_IRQ_STATUS)
        begin
            ev_status_q <= ev_set;
        end
        else
        begin
            ev_status_q <= ev_status_q | ev_set;
        end
    end

    // Mask bits only gate the interrupt; events are recorded regardless.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_mask_q <= WDT_MASK_RESET;
        end
        else if (wr_done && paddr == WDT_OFS_IRQ_MASK)
        begin
            ev_mask_q <= pwdata[WDT_EV_W-1:0];
        end
    end

    // The interrupt lags the status by one cycle so that it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(ev_status_q & ev_mask_q);
        end
    end

    // Reset status holds no storage, so service writes alter only its window-open bit.
    assign prdata = prdata_q; // R04
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign wdt_reset_req = reset_req_q;
    assign wdt_irq = irq_q;

endmodule : wdt_top

/* File: testbench/wdt_properties.sv */
/*
 * Port-level checker for the watchdog timer.
 * Assumes it is bound into wdt_top and sees only that module's ports.
 */
`timescale 1ns/1ns
module wdt_properties
    import wdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_reset_req,
    input wire logic wdt_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc_w0;
    assign acc_w0 = psel && penable && pready && pwrite && paddr == WDT_OFS_RESET_STATUS;
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    wait_state_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("bad answer time");
    bad_code_a: assert property (acc_w0 && pwdata != WDT_CODE_FIRST && pwdata != WDT_CODE_SECOND
        |=> wdt_reset_req) else $error("bad code gave no reset");
    req_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req) else $error("long reset pulse");
    unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr) else $error("no slave error");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    count_width_a: assert property (pready && !pwrite && paddr == WDT_OFS_COUNT
        |-> prdata[31:18] == 14'h0) else $error("count too wide");
endmodule : wdt_properties

bind wdt_top wdt_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq));

/* File: testbench/tb.sv */
/*
 * Self-checking bench for the watchdog timer, driven over APB.
 * Assumes the bench only counts reset requests and pulses presetn between test sections.
 */
`timescale 1ns/1ns
module tb
    import wdt_pkg::*;
;
    localparam int LPO = 4;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} wdt_row_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wdt_reset_req;
    logic wdt_irq;
    logic [31:0] rd;
    logic er;
    int n_errors = 0;
    int comparisons = 0;
    int n_req = 0;
    int cyc;
    int base;
    wdt_row_type rows [7] = '{'{0, 8'h04, 32'h0, 32'h3}, '{0, 8'h08, 32'h0, 32'h0},
        '{0, 8'h14, 32'h0, 32'h0}, '{1, 8'h14, 32'hf, 32'h0}, '{0, 8'h14, 32'h0, 32'hf},
        '{1, 8'h04, 32'h1, 32'h0}, '{0, 8'h04, 32'h0, 32'h1}};
    always #5 pclk = ~pclk;
    always @(posedge pclk)
        if (wdt_reset_req === 1'b1)
            n_req <= n_req + 1;
    wdt_top #(.LPO_DIV(LPO)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_reset_req(wdt_reset_req), .wdt_irq(wdt_irq));
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check
    // One idle edge before each setup keeps every signal to one assignment per time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_req(input int lim);
        cyc = 0;
        do
        begin
            @(posedge pclk);
            cyc++;
        end
        while (wdt_reset_req !== 1'b1 && cyc < lim);
    endtask : wait_req
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    task automatic stop_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (60000) @(posedge pclk);
        n_errors++;
        stop_test();
    end
    initial
    begin
        do_reset();
        wait_req(5000);
        check("default period", 32'(cyc >= 4080 && cyc <= 4112), 32'h1);
        do_reset();
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            check("row error", 32'(er), 32'h0);
            if (!rows[i].w)
                check("row data", rd, rows[i].e);
        end
        apb(0, 8'h20, 32'h0);
        check("unmapped error", 32'(er), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_FIRST);
        apb(0, WDT_OFS_RESET_STATUS, 32'h0);
        check("status after first code", rd, 32'h1 << WDT_RS_ENABLED_BIT);
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_SECOND);
        apb(0, WDT_OFS_COUNT, 32'h0);
        check("count after service", rd >> 1, 32'h0);
        apb(0, WDT_OFS_IRQ_STATUS, 32'h0);
        check("serviced event", rd, 32'h8);
        wait_req(400);
        check("slow short period", 32'(cyc >= 110 && cyc <= 135), 32'h1);
        repeat (3) @(posedge pclk);
        check("irq raised", 32'(wdt_irq), 32'h1);
        apb(0, WDT_OFS_IRQ_STATUS, 32'h0);
        check("timeout event", rd, 32'h1);
        repeat (3) @(posedge pclk);
        check("irq cleared", 32'(wdt_irq), 32'h0);
        apb(1, WDT_OFS_RESET_STATUS, 32'h12);
        wait_req(5);
        check("bad code", cyc, 32'h1);
        apb(0, WDT_OFS_IRQ_STATUS, 32'h0);
        check("bad code event", rd, 32'h1 << WDT_EV_BADCODE);
        do_reset();
        apb(1, WDT_OFS_OPTIONS_ONE, 32'h0);
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_SECOND);
        base = n_req;
        repeat (5000) @(posedge pclk);
        check("disabled", 32'(n_req - base), 32'h0);
        do_reset();
        apb(1, WDT_OFS_OPTIONS_TWO, 32'hc0);
        apb(1, WDT_OFS_OPTIONS_ONE, 32'h1);
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_FIRST);
        wait_req(5);
        check("early service", cyc, 32'h1);
        apb(0, WDT_OFS_IRQ_STATUS, 32'h0);
        check("early event", rd, 32'h1 << WDT_EV_EARLY);
        do_reset();
        apb(1, WDT_OFS_OPTIONS_TWO, 32'hc0);
        apb(1, WDT_OFS_OPTIONS_ONE, 32'h1);
        repeat (6200) @(posedge pclk);
        base = n_req;
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_FIRST);
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_SECOND);
        repeat (2) @(posedge pclk);
        check("late service", 32'(n_req - base), 32'h0);
        apb(1, WDT_OFS_OPTIONS_TWO, 32'h0);
        apb(0, WDT_OFS_OPTIONS_TWO, 32'h0);
        check("options locked", rd, 32'hc0);
        wait_req(9000);
        check("bus period", 32'(cyc >= 8170 && cyc <= 8200), 32'h1);
        do_reset();
        apb(1, WDT_OFS_OPTIONS_TWO, 32'h40);
        apb(1, WDT_OFS_OPTIONS_ONE, 32'h1);
        base = n_req;
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_FIRST);
        apb(1, WDT_OFS_RESET_STATUS, WDT_CODE_SECOND);
        repeat (2) @(posedge pclk);
        check("slow clock window", 32'(n_req - base), 32'h0);
        stop_test();
    end
endmodule : tb
